// file: hdl/arpt_params.svh
// Purpose: constants for the 12-bit autoreload PWM timer
// Assumes: APB byte addresses, one register per aligned word
// Notes:   definitions only
`ifndef ARPT_PARAMS_SVH
`define ARPT_PARAMS_SVH
`define ARPT_OFS_STATUS   12'h000
`define ARPT_OFS_COUNT    12'h004
`define ARPT_OFS_RELOAD   12'h008
`define ARPT_OFS_OUT_EN   12'h00C
`define ARPT_OFS_SYNC_INV 12'h010
`define ARPT_OFS_SHUTDOWN 12'h014
`define ARPT_OFS_CAPTURE  12'h018
`define ARPT_OFS_LOWPWR   12'h01C
`define ARPT_OFS_CHAN0    12'h020
`define ARPT_OFS_DUTY0    12'h040
`define ARPT_FLD_CMP_IRQ_EN 0
`define ARPT_FLD_OVF_IRQ_EN 1
`define ARPT_FLD_OVF_FLAG   2
`define ARPT_FLD_CK_LO      3
`define ARPT_FLD_CAP_IRQ_EN 5
`define ARPT_FLD_CAP_FLAG   6
`define ARPT_FLD_PAT_LO     0
`define ARPT_FLD_PIN_EN     4
`define ARPT_FLD_BA         5
`define ARPT_FLD_CMP_FLAG   0
`define ARPT_FLD_INVERT     1
`define ARPT_SLOW_DIV     32
`define ARPT_CNT_MAX      12'hFFF
`define ARPT_RST_SYNC     1'b1
`endif

// file: hdl/arpt_pkg.sv
// Purpose: types for the 12-bit autoreload PWM timer
// Assumes: nothing beyond the params header
// Notes:   clock select codes and APB carrier
package arpt_pkg;
   typedef enum logic [1:0] {
      ARPT_CK_OFF  = 2'b00,
      ARPT_CK_BASE = 2'b01,
      ARPT_CK_CPU  = 2'b10,
      ARPT_CK_FAST = 2'b11
   } arpt_ck_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } arpt_apb_req_t;
   typedef struct packed {
      logic        halt;
      logic        active_halt;
      logic        slow;
   } arpt_pwr_t;
endpackage : arpt_pkg

// file: hdl/arpt_timer.sv
// Purpose: 12-bit autoreload timer with four PWM outputs, compare, capture, break
// Assumes: count-source ticks arrive as one-cycle strobes on clk_i
// Notes:   APB slave, zero wait states, unmapped reads return zero
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "arpt_params.svh"
module arpt_timer
   import arpt_pkg::*;
#(
   parameter int CHANNELS = 4
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire arpt_pkg::arpt_apb_req_t apb_i,
   output logic                       pready_o,
   output logic                       pslverr_o,
   output logic [31:0]                prdata_o,
   input  wire logic                  tick_base_i,
   input  wire logic                  tick_fast_i,
   input  wire arpt_pkg::arpt_pwr_t   pwr_i,
   input  wire logic                  shutdown_n_i,
   input  wire logic                  capture_input_pin_i,
   input  wire logic [CHANNELS-1:0]   port_data_i,
   output logic [CHANNELS-1:0]        pwm_o,
   output logic                       irq_cmp_cap_o,
   output logic                       irq_ovf_o
);
   import arpt_pkg::*;

   if (CHANNELS != 4) begin : g_chan_chk
      $error("arpt_timer serves exactly four channels");
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [11:0]          counter_value_q;
   logic [11:0]          autoreload_value_q;
   logic [11:0]          duty_compare_value_q [CHANNELS];
   logic [11:0]          duty_active_q [CHANNELS];
   logic [CHANNELS-1:0]  channel_output_enable_q;
   logic [CHANNELS-1:0]  output_invert_q;
   logic [CHANNELS-1:0]  invert_active_q;
   logic [CHANNELS-1:0]  compare_flag_q;
   logic [CHANNELS-1:0]  pwm_level_q;
   logic [CHANNELS-1:0]  port_mode_q;
   logic [CHANNELS-1:0]  break_pattern_q;
   logic                 sync_inversion_q;
   logic                 shutdown_pin_enable_q;
   logic                 break_active_q;
   logic                 overflow_flag_q;
   logic                 overflow_irq_enable_q;
   logic                 compare_irq_enable_q;
   logic                 capture_irq_enable_q;
   logic                 capture_flag_q;
   logic [11:0]          capture_value_q;
   logic [1:0]           ck_sel_q;
   logic [4:0]           slow_cnt_q;
   logic [2:0]           brk_sync_q;
   logic [2:0]           cap_sync_q;
   logic [CHANNELS-1:0]  pwm_q;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic        wr_en;
   logic        rd_en;
   logic        ba_set_sw;
   logic        ba_clr_sw;
   logic        brk_pin;
   logic        brk_enter;
   logic        tick;
   logic        raw_tick;
   logic        ovf;
   logic        cap_edge;
   logic [11:0] addr;

   assign addr      = apb_i.paddr;
   assign wr_en     = apb_i.psel & apb_i.penable & apb_i.pwrite;
   assign rd_en     = apb_i.psel & apb_i.penable & ~apb_i.pwrite;
   assign pready_o  = 1'b1;
   assign pslverr_o = 1'b0;

   function automatic logic is_chan_addr(input logic [11:0] a, input logic [11:0] base);
      return (a >= base) && (a < base + 12'h010) && (a[1:0] == 2'b00);
   endfunction : is_chan_addr

   function automatic logic [1:0] chan_idx(input logic [11:0] a, input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      return d[3:2];
   endfunction : chan_idx

   ////////////////////////////////////////////////////////////////////////
   // Count source and low-power gating
   always_comb begin
      unique case (arpt_ck_t'(ck_sel_q))
         ARPT_CK_OFF:  raw_tick = 1'b0;
         ARPT_CK_BASE: raw_tick = tick_base_i;
         ARPT_CK_CPU:  raw_tick = 1'b1;
         ARPT_CK_FAST: raw_tick = tick_fast_i;
      endcase
   end

   // Slow mode: one tick in 32; halt mode has no input at all
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         slow_cnt_q <= 5'h00;
      end else if (raw_tick) begin
         slow_cnt_q <= slow_cnt_q + 5'h01;
      end
   end

   logic run_ok;
   assign run_ok = ~pwr_i.halt &
                   (~pwr_i.active_halt |
                    (ck_sel_q == ARPT_CK_BASE && overflow_irq_enable_q));
   assign tick = raw_tick & run_ok & (~pwr_i.slow | slow_cnt_q == 5'h1F);
   assign ovf  = tick & (counter_value_q == `ARPT_CNT_MAX);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers (three stages, stage 1 read only by stage 2)
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         brk_sync_q <= 3'h7;
         cap_sync_q <= 3'h0;
      end else begin
         brk_sync_q <= {brk_sync_q[1:0], shutdown_n_i};
         cap_sync_q <= {cap_sync_q[1:0], capture_input_pin_i};
      end
   end
   // Low only counts once stages two and three agree
   assign brk_pin  = shutdown_pin_enable_q & ~brk_sync_q[1] & ~brk_sync_q[2];
   logic cap_level_q;
   assign cap_edge = (cap_sync_q[1] == cap_sync_q[2]) &
                     (cap_sync_q[1] != cap_level_q);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) cap_level_q <= 1'b0;
      else if (cap_sync_q[1] == cap_sync_q[2]) cap_level_q <= cap_sync_q[2];
   end

   ////////////////////////////////////////////////////////////////////////
   // Break control
   assign ba_set_sw = wr_en && addr == `ARPT_OFS_SHUTDOWN && apb_i.pwdata[`ARPT_FLD_BA];
   assign ba_clr_sw = wr_en && addr == `ARPT_OFS_SHUTDOWN && !apb_i.pwdata[`ARPT_FLD_BA];
   assign brk_enter = brk_pin | ba_set_sw;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         break_active_q        <= 1'b0;
         shutdown_pin_enable_q <= 1'b0;
         break_pattern_q       <= 4'h0;
      end else begin
         if (wr_en && addr == `ARPT_OFS_SHUTDOWN) begin
            shutdown_pin_enable_q <= apb_i.pwdata[`ARPT_FLD_PIN_EN];
            break_pattern_q       <= apb_i.pwdata[3:0];
         end
         // Pin low wins over a software clear in the same cycle
         if (brk_enter) break_active_q <= 1'b1;
         else if (ba_clr_sw) break_active_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter and autoreload
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         counter_value_q    <= 12'h000;
         autoreload_value_q <= 12'h000;
      end else if (break_active_q) begin
         counter_value_q    <= 12'h000;
         autoreload_value_q <= 12'h000;
      end else begin
         if (ovf) counter_value_q <= autoreload_value_q;
         else if (tick) counter_value_q <= counter_value_q + 12'h001;
         if (wr_en && addr == `ARPT_OFS_RELOAD) autoreload_value_q <= apb_i.pwdata[11:0];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         overflow_flag_q <= 1'b0;
      end else if (ovf) begin
         overflow_flag_q <= 1'b1;
      end else if (rd_en && addr == `ARPT_OFS_STATUS) begin
         overflow_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ck_sel_q              <= 2'b00;
         overflow_irq_enable_q <= 1'b0;
         compare_irq_enable_q  <= 1'b0;
         capture_irq_enable_q  <= 1'b0;
         sync_inversion_q      <= `ARPT_RST_SYNC;
      end else begin
         if (wr_en && addr == `ARPT_OFS_STATUS) begin
            ck_sel_q              <= apb_i.pwdata[`ARPT_FLD_CK_LO +: 2];
            overflow_irq_enable_q <= apb_i.pwdata[`ARPT_FLD_OVF_IRQ_EN];
            compare_irq_enable_q  <= apb_i.pwdata[`ARPT_FLD_CMP_IRQ_EN];
            capture_irq_enable_q  <= apb_i.pwdata[`ARPT_FLD_CAP_IRQ_EN];
         end
         if (wr_en && addr == `ARPT_OFS_SYNC_INV) sync_inversion_q <= apb_i.pwdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channels
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         channel_output_enable_q <= '0;
         port_mode_q             <= '0;
         output_invert_q         <= '0;
         invert_active_q         <= '0;
         compare_flag_q          <= '0;
         pwm_level_q             <= '0;
         for (int i = 0; i < CHANNELS; i++) begin
            duty_compare_value_q[i] <= 12'h000;
            duty_active_q[i]        <= 12'h000;
         end
      end else begin
         if (break_active_q) begin
            channel_output_enable_q <= '0;
            port_mode_q             <= '1;
            for (int i = 0; i < CHANNELS; i++) begin
               duty_compare_value_q[i] <= 12'h000;
               duty_active_q[i]        <= 12'h000;
            end
         end else begin
            if (wr_en && addr == `ARPT_OFS_OUT_EN) begin
               channel_output_enable_q <= {apb_i.pwdata[6], apb_i.pwdata[4],
                                           apb_i.pwdata[2], apb_i.pwdata[0]};
            end
            if (ovf) port_mode_q <= ~channel_output_enable_q;
            for (int i = 0; i < CHANNELS; i++) begin
               if (wr_en && is_chan_addr(addr, `ARPT_OFS_DUTY0) &&
                   chan_idx(addr, `ARPT_OFS_DUTY0) == i[1:0]) begin
                  duty_compare_value_q[i] <= apb_i.pwdata[11:0];
               end
               if (ovf) begin
                  duty_active_q[i] <= duty_compare_value_q[i];
                  pwm_level_q[i]   <= 1'b1;
               end else if (tick && counter_value_q + 12'h001 == duty_active_q[i]) begin
                  pwm_level_q[i]   <= 1'b0;
               end
            end
         end
         for (int i = 0; i < CHANNELS; i++) begin
            if (wr_en && is_chan_addr(addr, `ARPT_OFS_CHAN0) &&
                chan_idx(addr, `ARPT_OFS_CHAN0) == i[1:0]) begin
               output_invert_q[i] <= apb_i.pwdata[`ARPT_FLD_INVERT];
            end
            if (!sync_inversion_q || ovf) invert_active_q[i] <= output_invert_q[i];
            // Hardware set wins over the read clear
            if (tick && duty_active_q[i] != 12'h000 &&
                counter_value_q == duty_active_q[i]) begin
               compare_flag_q[i] <= 1'b1;
            end else if (rd_en && is_chan_addr(addr, `ARPT_OFS_CHAN0) &&
                         chan_idx(addr, `ARPT_OFS_CHAN0) == i[1:0]) begin
               compare_flag_q[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture
   logic cap_read;
   assign cap_read = rd_en && addr == `ARPT_OFS_CAPTURE;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         capture_flag_q  <= 1'b0;
         capture_value_q <= 12'h000;
      end else if (cap_edge && !capture_flag_q) begin
         capture_flag_q  <= 1'b1;
         capture_value_q <= counter_value_q;
      end else if (cap_read && capture_flag_q) begin
         capture_flag_q  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwm_q <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (break_active_q) pwm_q[i] <= break_pattern_q[i];
            else if (channel_output_enable_q[i])
               pwm_q[i] <= pwm_level_q[i] ^ invert_active_q[i];
            else if (port_mode_q[i]) pwm_q[i] <= port_data_i[i];
            else pwm_q[i] <= invert_active_q[i];
         end
      end
   end
   assign pwm_o = pwm_q;

   assign irq_cmp_cap_o = (compare_irq_enable_q & |compare_flag_q) |
                          (capture_irq_enable_q & capture_flag_q);
   assign irq_ovf_o     = overflow_irq_enable_q & overflow_flag_q;

   always_comb begin
      prdata_o = 32'h0000_0000;
      if (rd_en) begin
         if (addr == `ARPT_OFS_STATUS)
            prdata_o[6:0] = {capture_flag_q, capture_irq_enable_q, ck_sel_q,
                             overflow_flag_q, overflow_irq_enable_q, compare_irq_enable_q};
         else if (addr == `ARPT_OFS_COUNT)    prdata_o[11:0] = counter_value_q;
         else if (addr == `ARPT_OFS_RELOAD)   prdata_o[11:0] = autoreload_value_q;
         else if (addr == `ARPT_OFS_OUT_EN)
            prdata_o[6:0] = {channel_output_enable_q[3], 1'b0, channel_output_enable_q[2], 1'b0,
                             channel_output_enable_q[1], 1'b0, channel_output_enable_q[0]};
         else if (addr == `ARPT_OFS_SYNC_INV) prdata_o[0] = sync_inversion_q;
         else if (addr == `ARPT_OFS_SHUTDOWN)
            prdata_o[5:0] = {break_active_q, shutdown_pin_enable_q, break_pattern_q};
         else if (addr == `ARPT_OFS_CAPTURE)  prdata_o[11:0] = capture_value_q;
         else if (is_chan_addr(addr, `ARPT_OFS_CHAN0))
            prdata_o[1:0] = {output_invert_q[chan_idx(addr, `ARPT_OFS_CHAN0)],
                             compare_flag_q[chan_idx(addr, `ARPT_OFS_CHAN0)]};
         else if (is_chan_addr(addr, `ARPT_OFS_DUTY0))
            prdata_o[11:0] = duty_compare_value_q[chan_idx(addr, `ARPT_OFS_DUTY0)];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   overflow_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovf && !break_active_q |=> counter_value_q == $past(autoreload_value_q) && overflow_flag_q)
      else $error("counter did not reload on overflow");
   count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tick && !ovf && !break_active_q |=> counter_value_q == $past(counter_value_q) + 12'h001)
      else $error("counter did not step");
   stop_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ck_sel_q == 2'b00 && !break_active_q |=> $stable(counter_value_q))
      else $error("counter moved with clock off");
   halt_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pwr_i.halt |-> !tick)
      else $error("tick during halt");
   break_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      break_active_q |=> counter_value_q == 12'h000 && channel_output_enable_q == '0)
      else $error("break did not reset timer");
   break_pattern_a: assert property (@(posedge clk_i) disable iff (rst_i)
      break_active_q |=> pwm_o == $past(break_pattern_q))
      else $error("break pattern not on pins");
   break_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
      brk_pin |=> break_active_q)
      else $error("shutdown pin did not set break");
   pin_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !shutdown_pin_enable_q && !ba_set_sw && !break_active_q |=> !break_active_q)
      else $error("break without enable");
   cap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      capture_flag_q && !cap_read |=> capture_flag_q && $stable(capture_value_q))
      else $error("capture changed while flag set");
   cap_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_read && capture_flag_q |=> !capture_flag_q)
      else $error("capture read did not clear flag");
   ovf_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ovf && overflow_irq_enable_q && !wr_en |=> irq_ovf_o)
      else $error("overflow request missing");
   cmp_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tick && duty_active_q[0] == 12'h000 && !compare_flag_q[0] |=> !compare_flag_q[0])
      else $error("compare event on zero duty");
   ovf_c: cover property (@(posedge clk_i) disable iff (rst_i) ovf);
   brk_c: cover property (@(posedge clk_i) disable iff (rst_i) brk_pin);
   cap_c: cover property (@(posedge clk_i) disable iff (rst_i) cap_edge && !capture_flag_q);
   cmp_c: cover property (@(posedge clk_i) disable iff (rst_i) irq_cmp_cap_o);
endmodule : arpt_timer

// file: verif/arpt_power_stage.sv
// Purpose: power converter stage model on the PWM pins
// Assumes: fault command from the bench, same clock
// Notes:   shutdown line is pulled up, so idle reads high
`timescale 1ns/100ps
module arpt_power_stage (
   input  wire logic       clk_i,
   input  wire logic       fault_i,
   input  wire logic [3:0] pwm_i,
   output logic            shutdown_n_o,
   output logic [3:0]      seen_o
);
   ////////////////////////////////////////////////////////////////
   // Pulls the line low on a fault; pull-up otherwise
   always_ff @(posedge clk_i) begin
      shutdown_n_o <= ~fault_i;
      seen_o       <= pwm_i;
   end
endmodule : arpt_power_stage

// file: verif/autoreload_pwm_timer_12bit_tb_top.sv
// Purpose: self-checking bench of the PWM timer over APB
// Assumes: zero-wait slave, CPU count source counts every clock
// Notes:   long waits cover one full 4096-count first period
`timescale 1ns/100ps
module autoreload_pwm_timer_12bit_tb_top;
   import arpt_pkg::*;
   logic          clk_i   = 1'b0;
   logic          rst_i   = 1'b1;
   arpt_apb_req_t apb     = '0;
   logic          cap_pin = 1'b0;
   logic          fault   = 1'b0;
   logic          tick_b  = 1'b0;
   logic          tick_f  = 1'b0;
   arpt_pwr_t     pwr     = '0;
   logic [3:0]    port    = 4'h5;
   logic          pready, pslverr, irq_cc, irq_ovf, shut_n;
   logic [31:0]   prdata, rd, c;
   logic [3:0]    pwm;
   int            errors = 0, tests_run = 0, cyc = 0, hi;

   initial forever #4 clk_i = ~clk_i;

   arpt_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb), .pready_o(pready),
      .pslverr_o(pslverr), .prdata_o(prdata), .tick_base_i(tick_b), .tick_fast_i(tick_f),
      .pwr_i(pwr), .shutdown_n_i(shut_n), .capture_input_pin_i(cap_pin),
      .port_data_i(port), .pwm_o(pwm), .irq_cmp_cap_o(irq_cc), .irq_ovf_o(irq_ovf));
   arpt_power_stage u_stage (.clk_i(clk_i), .fault_i(fault), .pwm_i(pwm),
      .shutdown_n_o(shut_n), .seen_o());

   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      apb <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_i);
      apb.penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      rd = prdata;
      apb <= '0;
   endtask : xfer

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle

   task automatic measure(output int n);
      n = 0;
      repeat (32) begin
         @(posedge clk_i);
         n += (pwm[0] === 1'b1);
      end
   endtask : measure

   task automatic flip;
      @(posedge clk_i);
      cap_pin <= ~cap_pin;
      idle(8);
   endtask : flip

   task automatic end_of_test;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////
   // Whole run is near 9000 cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         end_of_test();
      end
   end

   initial begin
      idle(20);
      rst_i <= 1'b0;
      xfer(0, 12'h000, 0); check(rd, 32'h0);
      xfer(0, 12'h004, 0); check(rd, 32'h0);
      xfer(0, 12'h010, 0); check(rd[0], 1);
      xfer(0, 12'h0FC, 0); check(rd, 32'h0);
      check(pslverr, 0);
      fault <= 1'b1;
      idle(10);
      xfer(0, 12'h014, 0); check(rd[5], 0);
      fault <= 1'b0;
      // Capture with the counter stopped, so the value is known
      xfer(1, 12'h000, 32'h10);
      idle(100);
      xfer(1, 12'h000, 32'h00);
      xfer(0, 12'h004, 0);
      c = rd;
      flip();
      xfer(0, 12'h000, 0); check(rd[6], 1);
      xfer(1, 12'h000, 32'h30);
      idle(1); check(irq_cc, 1);
      flip();
      xfer(1, 12'h000, 32'h20);
      xfer(0, 12'h018, 0); check(rd, c);
      xfer(0, 12'h000, 0); check(rd, 32'h20);
      idle(1); check(irq_cc, 0);
      // Gating and sources; reads lie idle plus 3 edges apart
      pwr <= '{1'b1, 1'b0, 1'b0};
      xfer(1, 12'h000, 32'h10);
      xfer(0, 12'h004, 0); c = rd;
      idle(29);
      xfer(0, 12'h004, 0); check(rd, c);
      // 64 edges in slow mode give exactly two steps
      pwr <= '{1'b0, 1'b0, 1'b1};
      xfer(0, 12'h004, 0); c = rd;
      idle(61);
      xfer(0, 12'h004, 0); check(rd, c + 32'h2);
      pwr <= '{1'b0, 1'b1, 1'b0};
      tick_b <= 1'b1;
      xfer(1, 12'h000, 32'h0A);
      xfer(0, 12'h004, 0); c = rd;
      idle(29);
      xfer(0, 12'h004, 0); check(rd, c + 32'h20);
      xfer(1, 12'h000, 32'h08);
      xfer(0, 12'h004, 0); c = rd;
      idle(29);
      xfer(0, 12'h004, 0); check(rd, c);
      pwr <= '0;
      tick_b <= 1'b0;
      tick_f <= 1'b1;
      xfer(1, 12'h000, 32'h18);
      xfer(0, 12'h004, 0); c = rd;
      idle(29);
      xfer(0, 12'h004, 0); check(rd, c + 32'h20);
      // Period of 16 counts, high for 12
      xfer(1, 12'h008, 32'hFF0);
      xfer(1, 12'h040, 32'hFFC);
      xfer(1, 12'h00C, 32'h1);
      xfer(1, 12'h000, 32'h12);
      idle(4200);
      measure(hi); check(hi, 24);
      check(irq_ovf, 1);
      xfer(0, 12'h000, 0); check(rd[2], 1);
      xfer(0, 12'h020, 0); check(rd[0], 1);
      xfer(0, 12'h024, 0); check(rd[0], 0);
      xfer(1, 12'h000, 32'h13);
      idle(20); check(irq_cc, 1);
      xfer(1, 12'h020, 32'h2);
      idle(40);
      measure(hi); check(hi, 8);
      xfer(1, 12'h020, 32'h0);
      // Break from the pin, then hand-over to the port
      xfer(1, 12'h014, 32'h1A);
      fault <= 1'b1;
      idle(10); check(pwm, 4'hA);
      xfer(0, 12'h014, 0); check(rd, 32'h3A);
      xfer(0, 12'h008, 0); check(rd, 32'h0);
      xfer(0, 12'h00C, 0); check(rd, 32'h0);
      xfer(0, 12'h040, 0); check(rd, 32'h0);
      fault <= 1'b0;
      idle(8);
      xfer(1, 12'h014, 32'h0A);
      idle(4200); check(pwm, port);
      xfer(1, 12'h014, 32'h23);
      idle(3); check(pwm, 4'h3);
      end_of_test();
   end
endmodule : autoreload_pwm_timer_12bit_tb_top
